// >>> inc/pd_policy_map.svh
// register map, field positions, reset values and thresholds of the port policy bank
// assumes an 8-bit register address space and 8-bit data from the serial slave engine
`ifndef PD_POLICY_MAP_SVH
`define PD_POLICY_MAP_SVH

`define PD_POLICY_ONE_ADDR 8'h16
`define PD_POLICY_TWO_ADDR 8'h17
`define PD_POLICY_ONE_RESET 8'h00
`define PD_POLICY_TWO_RESET 8'h05
`define PD_READ_UNMAPPED 8'h00

`define PD_ONE_CDP_BIT 7
`define PD_ONE_LEGACY_HI 6
`define PD_ONE_LEGACY_LO 5
`define PD_ONE_COMM_BIT 4
`define PD_ONE_DERATE_BIT 3
`define PD_ONE_TTEMP_HI 2
`define PD_ONE_TTEMP_LO 1
`define PD_ONE_ADVERT_BIT 0

`define PD_TWO_HRST_BIT 7
`define PD_TWO_SUSPEND_BIT 6
`define PD_TWO_TCUR_HI 5
`define PD_TWO_TCUR_LO 3
`define PD_TWO_COMPL_HI 2
`define PD_TWO_COMPL_LO 0

`define PD_LEGACY_ALL 2'h0
`define PD_LEGACY_DIVIDER 2'h1
`define PD_TTEMP_MAX 2'h2
`define PD_BYTE_PAD2 6'h00
`define PD_BYTE_PAD3 5'h00

`define PD_PDP_3A_MIN_W 8'h0f
`define PD_PULLUP_3A_UA 9'h14a
`define PD_ATTACH_3A_LO_MV 12'h352
`define PD_ATTACH_3A_HI_MV 12'h992
`define PD_PULLUP_1P5_UA 9'h0b4
`define PD_ATTACH_1P5_LO_MV 12'h352
`define PD_ATTACH_1P5_HI_MV 12'h992

`endif

// >>> inc/pd_policy_pkg.sv
// types shared by the port policy register bank and its two helpers
// assumes pd_policy_map.svh is compiled alongside for the numeric constants
package pd_policy_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic cdp_only;
		logic bc12;
		logic divider;
		logic hv_vendor;
		logic vendor_1v2;
	} scheme_en_t;

	typedef struct packed {
		logic thermistor_event;
		logic overtemp_warning_one;
		logic overtemp_warning_two;
	} thermal_t;

	typedef struct packed {
		logic adv_1p5;
		logic [8:0] pullup_ua;
		logic attached;
	} cc_advert_t;

	typedef struct packed {
		logic [7:0] byte12;
		logic [7:0] byte13;
		logic [7:0] byte20;
	} ext_caps_t;

	typedef enum logic [0:0] {
		HR_IDLE,
		HR_WAIT
	} hr_state_t;

	typedef struct packed {
		logic [7:0] one;
		logic [7:0] two;
		hr_state_t hr_st;
		logic hr_start;
		logic [7:0] rdata;
		logic rvalid;
		scheme_en_t scheme;
		cc_advert_t cc;
		ext_caps_t caps;
		logic usb_comm;
		logic suspend;
	} policy_state_t;

endpackage

// >>> verilog/pd_charge_scheme_decode.sv
// legacy charging scheme decoder, purely combinational
// assumes the caller registers the result before it leaves the block
`timescale 1ns/10ps
`default_nettype none
`include "pd_policy_map.svh"

module pd_charge_scheme_decode (
	input wire logic cdp_select,
	input wire logic [1:0] scheme_select,
	output pd_policy_pkg::scheme_en_t scheme_en
);

	always_comb begin
		scheme_en = '0;
		if (cdp_select) begin
			// downstream port charging excludes every dedicated charger scheme
			scheme_en.cdp_only = 1'b1;
		end else begin
			unique case (scheme_select)
				`PD_LEGACY_ALL: begin
					scheme_en.bc12 = 1'b1;
					scheme_en.divider = 1'b1;
					scheme_en.hv_vendor = 1'b1;
					scheme_en.vendor_1v2 = 1'b1;
				end
				`PD_LEGACY_DIVIDER: begin
					scheme_en.bc12 = 1'b1;
					scheme_en.divider = 1'b1;
				end
				default: begin
					scheme_en.bc12 = 1'b1;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// >>> verilog/pd_cc_advert_select.sv
// chooses the advertised type-c current level and judges sink attach
// assumes cc_sense_mv is a settled millivolt reading of the active cc line
`timescale 1ns/10ps
`default_nettype none
`include "pd_policy_map.svh"

module pd_cc_advert_select (
	input wire logic advert_1p5_select,
	input wire logic derate_select,
	input wire pd_policy_pkg::thermal_t thermal,
	input wire logic [7:0] source_power_rating,
	input wire logic [11:0] cc_sense_mv,
	output pd_policy_pkg::cc_advert_t advert
);

	logic hot;
	logic low_power;
	logic [11:0] lo_mv;
	logic [11:0] hi_mv;

	always_comb begin
		hot = thermal.thermistor_event | thermal.overtemp_warning_one |
			thermal.overtemp_warning_two;
		low_power = source_power_rating < `PD_PDP_3A_MIN_W;
		advert.adv_1p5 = advert_1p5_select;
		if (derate_select) begin
			advert.adv_1p5 = advert_1p5_select | hot;
		end else begin
			advert.adv_1p5 = advert_1p5_select | low_power;
		end
		if (advert.adv_1p5) begin
			advert.pullup_ua = `PD_PULLUP_1P5_UA;
			lo_mv = `PD_ATTACH_1P5_LO_MV;
			hi_mv = `PD_ATTACH_1P5_HI_MV;
		end else begin
			advert.pullup_ua = `PD_PULLUP_3A_UA;
			lo_mv = `PD_ATTACH_3A_LO_MV;
			hi_mv = `PD_ATTACH_3A_HI_MV;
		end
		advert.attached = (cc_sense_mv >= lo_mv) && (cc_sense_mv <= hi_mv);
	end

endmodule
`default_nettype wire

// >>> verilog/pd_port_policy_control_regs.sv
// port policy register bank: two 8-bit control registers behind the serial slave engine
// assumes the slave engine delivers one-cycle wr/rd strobes with address and data,
// and that the protocol engine pulses hard_reset_sent once a requested hard reset is out
`timescale 1ns/10ps
`default_nettype none
`include "pd_policy_map.svh"

module pd_port_policy_control_regs (
	input wire logic clk,
	input wire logic rst_b,
	input wire pd_policy_pkg::reg_req_t reg_req,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire pd_policy_pkg::thermal_t thermal,
	input wire logic [7:0] source_power_rating,
	input wire logic [11:0] cc_sense_mv,
	input wire logic hard_reset_sent,
	output logic hard_reset_start,
	output logic hard_reset_busy,
	output pd_policy_pkg::scheme_en_t scheme_en,
	output pd_policy_pkg::cc_advert_t cc_advert,
	output pd_policy_pkg::ext_caps_t ext_caps,
	output logic usb_comm_capable,
	output logic suspend_supported
);

	pd_policy_pkg::policy_state_t state_r;
	pd_policy_pkg::policy_state_t state_nxt;
	pd_policy_pkg::scheme_en_t scheme_comb;
	pd_policy_pkg::cc_advert_t advert_comb;

	// register address decode, shared by the read and the write path
	function automatic logic hits(input logic [7:0] addr, input logic [7:0] reg_addr);
		hits = addr == reg_addr;
	endfunction

	// pads a narrow field into a message byte at bit 0
	function automatic logic [7:0] caps_byte3(input logic [2:0] field);
		caps_byte3 = {`PD_BYTE_PAD3, field};
	endfunction

	function automatic logic [7:0] caps_byte2(input logic [1:0] field);
		caps_byte2 = {`PD_BYTE_PAD2, field};
	endfunction

	pd_charge_scheme_decode scheme_dec (
		.cdp_select(state_r.one[`PD_ONE_CDP_BIT]),
		.scheme_select(state_r.one[`PD_ONE_LEGACY_HI:`PD_ONE_LEGACY_LO]),
		.scheme_en(scheme_comb)
	);

	pd_cc_advert_select advert_sel (
		.advert_1p5_select(state_r.one[`PD_ONE_ADVERT_BIT]),
		.derate_select(state_r.one[`PD_ONE_DERATE_BIT]),
		.thermal(thermal),
		.source_power_rating(source_power_rating),
		.cc_sense_mv(cc_sense_mv),
		.advert(advert_comb)
	);

	always_comb begin
		logic wr_one;
		logic wr_two;
		logic hr_set;
		logic hr_done;
		logic [7:0] one_w;
		wr_one = 1'b0;
		wr_two = 1'b0;
		hr_set = 1'b0;
		hr_done = 1'b0;
		one_w = '0;

		state_nxt = state_r;
		state_nxt.hr_start = 1'b0;
		state_nxt.rvalid = 1'b0;

		wr_one = reg_req.wr && hits(reg_req.addr, `PD_POLICY_ONE_ADDR);
		wr_two = reg_req.wr && hits(reg_req.addr, `PD_POLICY_TWO_ADDR);

		// first control register: plain storage apart from the temperature field
		if (wr_one) begin
			one_w = reg_req.wdata;
			// only 0..2 are legal contact temperatures; an illegal code keeps the old one
			if (reg_req.wdata[`PD_ONE_TTEMP_HI:`PD_ONE_TTEMP_LO] > `PD_TTEMP_MAX) begin
				one_w[`PD_ONE_TTEMP_HI:`PD_ONE_TTEMP_LO] =
					state_r.one[`PD_ONE_TTEMP_HI:`PD_ONE_TTEMP_LO];
			end
			state_nxt.one = one_w;
		end

		// second control register: low seven bits are plain storage
		if (wr_two) begin
			state_nxt.two[`PD_TWO_SUSPEND_BIT:`PD_TWO_COMPL_LO] =
				reg_req.wdata[`PD_TWO_SUSPEND_BIT:`PD_TWO_COMPL_LO];
		end

		// hard reset request; a write of 0 to the request bit never clears it
		hr_set = wr_two && reg_req.wdata[`PD_TWO_HRST_BIT];
		hr_done = hard_reset_sent && (state_r.hr_st == pd_policy_pkg::HR_WAIT);
		unique case (state_r.hr_st)
			pd_policy_pkg::HR_IDLE: begin
				if (hr_set) begin
					state_nxt.two[`PD_TWO_HRST_BIT] = 1'b1;
					state_nxt.hr_st = pd_policy_pkg::HR_WAIT;
					state_nxt.hr_start = 1'b1;
				end
			end
			pd_policy_pkg::HR_WAIT: begin
				if (hr_done) begin
					state_nxt.two[`PD_TWO_HRST_BIT] = 1'b0;
					state_nxt.hr_st = pd_policy_pkg::HR_IDLE;
				end
				// a new request in the finishing cycle wins and starts another reset
				if (hr_done && hr_set) begin
					state_nxt.two[`PD_TWO_HRST_BIT] = 1'b1;
					state_nxt.hr_st = pd_policy_pkg::HR_WAIT;
					state_nxt.hr_start = 1'b1;
				end
			end
		endcase

		// reads show stored values, including the live request bit; unmapped reads 0
		if (reg_req.rd) begin
			state_nxt.rvalid = 1'b1;
			if (hits(reg_req.addr, `PD_POLICY_ONE_ADDR)) begin
				state_nxt.rdata = state_r.one;
			end else if (hits(reg_req.addr, `PD_POLICY_TWO_ADDR)) begin
				state_nxt.rdata = state_r.two;
			end else begin
				state_nxt.rdata = `PD_READ_UNMAPPED;
			end
		end

		// derived port behaviour, one cycle behind the stored fields so every
		// output leaves a flip-flop; a cycle of lag is far below any cc timing
		state_nxt.scheme = scheme_comb;
		state_nxt.cc = advert_comb;
		state_nxt.caps.byte12 = caps_byte3(
			state_r.two[`PD_TWO_COMPL_HI:`PD_TWO_COMPL_LO]);
		state_nxt.caps.byte13 = caps_byte3(
			state_r.two[`PD_TWO_TCUR_HI:`PD_TWO_TCUR_LO]);
		state_nxt.caps.byte20 = caps_byte2(
			state_r.one[`PD_ONE_TTEMP_HI:`PD_ONE_TTEMP_LO]);
		state_nxt.usb_comm = state_r.one[`PD_ONE_COMM_BIT];
		state_nxt.suspend = state_r.two[`PD_TWO_SUSPEND_BIT];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r.one <= `PD_POLICY_ONE_RESET;
			state_r.two <= `PD_POLICY_TWO_RESET;
			state_r.hr_st <= pd_policy_pkg::HR_IDLE;
			state_r.hr_start <= 1'b0;
			state_r.rdata <= `PD_READ_UNMAPPED;
			state_r.rvalid <= 1'b0;
			state_r.scheme <= '0;
			state_r.cc <= '0;
			state_r.caps <= '0;
			state_r.usb_comm <= 1'b0;
			state_r.suspend <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign rd_data = state_r.rdata;
	assign rd_valid = state_r.rvalid;
	assign hard_reset_start = state_r.hr_start;
	assign hard_reset_busy = state_r.two[`PD_TWO_HRST_BIT];
	assign scheme_en = state_r.scheme;
	assign cc_advert = state_r.cc;
	assign ext_caps = state_r.caps;
	assign usb_comm_capable = state_r.usb_comm;
	assign suspend_supported = state_r.suspend;

endmodule
`default_nettype wire

// >>> sim/pd_hr_engine_model.sv
// protocol engine stand-in that reports a hard reset as sent
// assumes start is a one-cycle pulse; lag sets how slowly it answers
`timescale 1ns/10ps
`default_nettype none
module pd_hr_engine_model (
	input wire logic clk,
	input wire logic start,
	input wire logic [7:0] lag,
	output logic sent
);
	initial begin
		sent = 1'b0;
		forever begin
			@(posedge clk);
			#1;
			// a start raised in the finishing cycle is still high here, so look again
			while (start === 1'b1) begin
				repeat (lag) @(posedge clk);
				#1 sent = 1'b1;
				@(posedge clk);
				#1 sent = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/pd_policy_checker.sv
// assertions on the port policy bank, bound to its top module
// assumes the one-cycle read latency and two-edge output lag of the bank
`timescale 1ns/10ps
`default_nettype none
module pd_policy_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire pd_policy_pkg::reg_req_t reg_req,
	input wire logic rd_valid,
	input wire logic [11:0] cc_sense_mv,
	input wire logic hard_reset_sent,
	input wire logic hard_reset_start,
	input wire logic hard_reset_busy,
	input wire pd_policy_pkg::scheme_en_t scheme_en,
	input wire pd_policy_pkg::cc_advert_t cc_advert,
	input wire pd_policy_pkg::ext_caps_t ext_caps
);
	logic set_req;
	assign set_req = reg_req.wr && reg_req.addr == 8'h17 && reg_req.wdata[7];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// outputs hold reset values until one edge after release
	sequence up2;
		rst_b && $past(rst_b);
	endsequence
	sequence hr_take;
		set_req && (!hard_reset_busy || hard_reset_sent);
	endsequence
	sequence hr_done;
		hard_reset_busy && hard_reset_sent;
	endsequence
	charge_excl_a: assert property (scheme_en.cdp_only |-> scheme_en[3:0] == 4'h0)
		else $error("other schemes on");
	scheme_nest_a: assert property (up2 |-> scheme_en.cdp_only != scheme_en.bc12
		&& (!scheme_en.hv_vendor || scheme_en.divider)) else $error("scheme set bad");
	pullup_a: assert property (up2 |-> cc_advert.pullup_ua ==
		(cc_advert.adv_1p5 ? 9'h0b4 : 9'h14a)) else $error("pull-up bad");
	attach_a: assert property (up2 |=> cc_advert.attached ==
		($past(cc_sense_mv) >= 12'h352 && $past(cc_sense_mv) <= 12'h992)) else $error("attach");
	caps_pad_a: assert property (ext_caps.byte12[7:3] == 5'h00
		&& ext_caps.byte13[7:3] == 5'h00) else $error("caps pad");
	temp_code_a: assert property (ext_caps.byte20[7:2] == 6'h00
		&& ext_caps.byte20[1:0] != 2'h3) else $error("temp code");
	hr_start_a: assert property (hr_take |=> hard_reset_start && hard_reset_busy
		##1 !hard_reset_start) else $error("start pulse");
	hr_hold_a: assert property (hard_reset_busy && !hard_reset_sent |=> hard_reset_busy)
		else $error("busy dropped");
	hr_clear_a: assert property (hr_done ##0 !set_req |=> !hard_reset_busy)
		else $error("busy stuck");
	rd_lat_a: assert property (up2 |-> rd_valid == $past(reg_req.rd))
		else $error("read latency");
endmodule
bind pd_port_policy_control_regs pd_policy_checker chk (.clk, .rst_b, .reg_req, .rd_valid,
	.cc_sense_mv, .hard_reset_sent, .hard_reset_start, .hard_reset_busy, .scheme_en,
	.cc_advert, .ext_caps);
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the port policy register bank
// assumes the engine model answers hard reset starts
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	pd_policy_pkg::reg_req_t req = '0;
	pd_policy_pkg::thermal_t th = '0;
	logic [7:0] spr = 8'h00;
	logic [11:0] mv = 12'h000;
	logic [7:0] lag = 8'h01;
	logic [7:0] rd_data;
	logic rd_valid, sent, hr_go, busy, comm, susp;
	pd_policy_pkg::scheme_en_t sch;
	pd_policy_pkg::cc_advert_t adv;
	pd_policy_pkg::ext_caps_t caps;
	logic [7:0] expq[$];
	logic [7:0] one, two, e;
	int bad_count = 0;
	int samples_checked = 0;
	int starts = 0;
	always #5 clk = ~clk;
	pd_port_policy_control_regs dut (.clk, .rst_b, .reg_req(req), .rd_data, .rd_valid,
		.thermal(th), .source_power_rating(spr), .cc_sense_mv(mv), .hard_reset_sent(sent),
		.hard_reset_start(hr_go), .hard_reset_busy(busy), .scheme_en(sch), .cc_advert(adv),
		.ext_caps(caps), .usb_comm_capable(comm), .suspend_supported(susp));
	pd_hr_engine_model peer (.clk, .start(hr_go), .lag, .sent);
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 req = {w, !w, a, d};
		@(posedge clk);
		#1 req = '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		expq.push_back(x);
		bus(1'b0, a, 8'h00);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// an unexpected read answer meets an unknown note and fails
	always @(negedge clk) begin
		if (hr_go === 1'b1)
			starts++;
		if (rd_valid === 1'b1) begin
			e = expq.size() ? expq.pop_front() : 8'hxx;
			cmp(24'(rd_data), 24'(e));
		end
	end
	initial begin
		void'($urandom(32'he424));
		repeat (2) @(posedge clk);
		#1 rst_b = 1'b1;
		rd(8'h16, 8'h00);
		rd(8'h17, 8'h05);
		rd(8'h3c, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 8'h16, {i[2:0], 5'h00});
			settle();
			e = i[2] ? 8'h10 : (i[1:0] == 0 ? 8'h0f : (i[1:0] == 1 ? 8'h0c : 8'h08));
			cmp(24'(sch), 24'(e));
		end
		$display("scheme test done");
		for (int i = 0; i < 40; i++) begin
			one = 8'($urandom) & 8'h19;
			th = 3'($urandom);
			spr = 8'($urandom_range(13, 16));
			mv = 12'($urandom_range(845, 2455));
			bus(1'b1, 8'h16, one);
			settle();
			e[0] = one[0] | (one[3] ? |th : spr < 8'h0f);
			cmp(24'(adv), 24'({e[0], e[0] ? 9'h0b4 : 9'h14a,
				mv >= 12'h352 && mv <= 12'h992}));
			cmp(24'(comm), 24'(one[4]));
		end
		$display("advert test done");
		for (int i = 0; i < 4; i++) begin
			two = 8'($urandom) & 8'h7f;
			bus(1'b1, 8'h16, {5'h00, i[1:0], 1'b0});
			bus(1'b1, 8'h17, two);
			settle();
			one = {5'h00, i == 3 ? 2'h2 : i[1:0], 1'b0};
			cmp(24'(caps), {5'h00, two[2:0], 5'h00, two[5:3], 6'h00, one[2:1]});
			cmp(24'(susp), 24'(two[6]));
			rd(8'h16, one);
		end
		$display("caps test done");
		// k=2 lands the second request in the cycle in which the first one is sent
		for (int k = 0; k < 3; k++) begin
			lag = k == 1 ? 8'h14 : 8'h01;
			starts = 0;
			bus(1'b1, 8'h17, 8'h80 | two);
			if (k != 2)
				rd(8'h17, 8'h80 | two);
			if (k != 0)
				bus(1'b1, 8'h17, 8'h80 | two);
			for (int n = 0; n < 60 && busy !== 1'b0; n++) @(negedge clk);
			rd(8'h17, two);
			bus(1'b1, 8'h17, two);
			settle();
			cmp(24'({busy, starts[1:0]}), 24'(k == 2 ? 2 : 1));
		end
		$display("hard reset test done");
		wrap_up();
	end
	initial begin
		#300000;
		bad_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
